// ### logic/ekw_top.sv
// External, key-sense and wake-up interrupt front end with Wishbone registers.
//
// What this block does
// - Upper key mask bit 0 enables, 1 blocks its key input; reset 1.
// - Lower key mask bit 6 also gates request pin 6; resets 0.
// - Wake mask bit 0 enables, 1 blocks its wake input; reset 1.
// - Any upper key or wake mask bit at 0 ignores pin 7.
// - Wake and upper keys feed source 7; lower keys feed source 6.
// - Keys and wake inputs use sense, enable, level, flag of sources 6/7.
// - Non-maskable request is highest and never gated by masks or mode.
// - A control bit picks rising or falling edge for non-maskable pin.
// - Each request pin has its own vector and selectable sense.
// - Enable bit forwards each request; control level per request.
// - Status flag sets on its sense condition regardless of enable.
// - Detection ignores the pin direction setting.
// - Non-maskable and sources 7,6,2,1,0 wake from standby; others not.
// - Peripheral request only while its flag set and enable is 1.
// - Transfer controller requests ignore control mode and CPU masks.
// - Sense code: 00 low, 01 falling, 10 rising, 11 both edges.
// - Status flag clears on 0 write after reading it as 1.
// - Edge mode auto-clears on exception; low mode only if pin high.
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
module ekw_top
    import ekw_pkg::*;
(
    input  wire logic                           clock,
    input  wire logic                           arst_n,
    input  wire logic                           wb_cyc_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_we_i,
    input  wire logic [ekw_pkg::ADDR_W-1:0]     wb_adr_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic [ekw_pkg::DATA_W-1:0]     wb_dat_i,
    output logic      [ekw_pkg::DATA_W-1:0]     wb_dat_o,
    output logic                                wb_ack_o,
    input  wire logic                           nmi_pin,
    input  wire logic [ekw_pkg::N_IRQ-1:0]      irq_pin_n,
    input  wire logic [ekw_pkg::N_KEY-1:0]      key_sense_inputs_n,
    input  wire logic [ekw_pkg::N_WAKE-1:0]     wake_event_inputs_n,
    input  wire logic                           nmi_exc_ack,
    input  wire logic [ekw_pkg::N_IRQ-1:0]      irq_exc_ack,
    input  wire logic                           standby,
    input  wire logic [ekw_pkg::N_PERIPH-1:0]   periph_flag,
    input  wire logic [ekw_pkg::N_PERIPH-1:0]   periph_en,
    input  wire logic [ekw_pkg::N_PERIPH-1:0]   periph_dtc_sel,
    output logic                                nmi_req,
    output logic      [ekw_pkg::N_IRQ-1:0]      irq_req,
    output logic      [ekw_pkg::N_IRQ-1:0]      irq_level,
    output logic      [ekw_pkg::N_PERIPH-1:0]   periph_req,
    output logic      [ekw_pkg::N_PERIPH-1:0]   dtc_req,
    output logic                                wake
);

    // ========================================================================
    // Declarations
    logic [7:0]        sys_ctrl_ff,   nxt_sys_ctrl;
    logic [15:0]       sense_sel_ff,  nxt_sense_sel;
    logic [7:0]        req_enable_ff, nxt_req_enable;
    logic [7:0]        ctrl_level_ff, nxt_ctrl_level;
    logic [7:0]        key_upper_ff,  nxt_key_upper;
    logic [7:0]        key_lower_ff,  nxt_key_lower;
    logic [7:0]        wake_mask_ff,  nxt_wake_mask;
    logic [7:0]        read_seen_ff,  nxt_read_seen;
    logic [DATA_W-1:0] dat_ff,        nxt_dat;
    logic              ack_ff,        nxt_ack;
    logic              nmi_prev_ff,   nxt_nmi_prev;
    logic              nmi_flag_ff,   nxt_nmi_flag;
    logic [7:0]        irq_req_ff,    nxt_irq_req;
    logic [7:0]        irq_level_ff,  nxt_irq_level;
    logic [N_PERIPH-1:0] periph_req_ff, nxt_periph_req;
    logic [N_PERIPH-1:0] dtc_req_ff,    nxt_dtc_req;
    logic              wake_ff,       nxt_wake;
    logic              access;
    logic              wr;
    logic              rd;
    logic [7:0]        sw_clear;
    logic [7:0]        flags;
    logic [7:0]        line_n;
    logic              pin7_ignored;
    logic              line6_n;
    logic              line7_n;
    logic              nmi_edge;

    // ========================================================================
    // Merging of key and wake inputs onto sources 6 and 7
    always_comb
    begin
        // pin 7 dropped when any upper key or wake input unmasked
        pin7_ignored = !(&key_upper_ff) || !(&wake_mask_ff);
        // any unmasked low input pulls its merged line low
        // lower keys plus gated pin 6
        line6_n = (&(key_sense_inputs_n[7:0] | key_lower_ff))
                  && (irq_pin_n[KEY_IRQ_LOWER] || key_lower_ff[PIN6_MASK_BIT]);
        // upper keys and wake feed 7
        line7_n = (&(key_sense_inputs_n[15:8] | key_upper_ff))
                  && (&(wake_event_inputs_n | wake_mask_ff))
                  && (irq_pin_n[KEY_IRQ_UPPER] || pin7_ignored);
        line_n = irq_pin_n;
        line_n[KEY_IRQ_LOWER] = line6_n;
        line_n[KEY_IRQ_UPPER] = line7_n;
    end

    // ========================================================================
    // Per-source detectors
    genvar gi;
    generate
        for (gi = 0; gi < N_IRQ; gi++)
        begin : g_src
            // each pin has its own detector and sense code
            ekw_sense u_sense (
                .clock    (clock),
                .arst_n   (arst_n),
                .line_n   (line_n[gi]),
                .mode     (sense_sel_ff[2*gi+1:2*gi]),
                .sw_clear (sw_clear[gi]),
                .exc_ack  (irq_exc_ack[gi]),
                .flag     (flags[gi])
            );
        end
    endgenerate

    // ========================================================================
    // Wishbone slave and register file
    assign access = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr     = access && wb_we_i;
    assign rd     = access && !wb_we_i;

    always_comb
    begin
        nxt_sys_ctrl   = sys_ctrl_ff;
        nxt_sense_sel  = sense_sel_ff;
        nxt_req_enable = req_enable_ff;
        nxt_ctrl_level = ctrl_level_ff;
        nxt_key_upper  = key_upper_ff;
        nxt_key_lower  = key_lower_ff;
        nxt_wake_mask  = wake_mask_ff;
        nxt_read_seen  = read_seen_ff;
        nxt_dat        = dat_ff;
        nxt_ack        = access;
        sw_clear       = 8'h00;
        if (wr && wb_sel_i[0])
        begin
            case (wb_adr_i)
                OFS_SYS_CTRL:   nxt_sys_ctrl   = wb_dat_i[7:0];
                OFS_SENSE_SEL:  nxt_sense_sel[7:0] = wb_dat_i[7:0];
                OFS_REQ_ENABLE: nxt_req_enable = wb_dat_i[7:0];
                OFS_CTRL_LEVEL: nxt_ctrl_level = wb_dat_i[7:0];
                OFS_KEY_UPPER:  nxt_key_upper  = wb_dat_i[7:0];
                OFS_KEY_LOWER:  nxt_key_lower  = wb_dat_i[7:0];
                OFS_WAKE_MASK:  nxt_wake_mask  = wb_dat_i[7:0];
                OFS_REQ_STATUS:
                begin
                    sw_clear      = read_seen_ff & ~wb_dat_i[7:0];
                    nxt_read_seen = 8'h00;
                end
                default:        nxt_sys_ctrl   = sys_ctrl_ff;
            endcase
        end
        if (wr && wb_sel_i[1] && (wb_adr_i == OFS_SENSE_SEL))
        begin
            nxt_sense_sel[15:8] = wb_dat_i[15:8];
        end
        if (rd)
        begin
            case (wb_adr_i)
                OFS_SYS_CTRL:   nxt_dat = {24'h00_0000, sys_ctrl_ff};
                OFS_SENSE_SEL:  nxt_dat = {16'h0000, sense_sel_ff};
                OFS_REQ_ENABLE: nxt_dat = {24'h00_0000, req_enable_ff};
                OFS_REQ_STATUS: nxt_dat = {24'h00_0000, flags};
                OFS_CTRL_LEVEL: nxt_dat = {24'h00_0000, ctrl_level_ff};
                OFS_KEY_UPPER:  nxt_dat = {24'h00_0000, key_upper_ff};
                OFS_KEY_LOWER:  nxt_dat = {24'h00_0000, key_lower_ff};
                OFS_WAKE_MASK:  nxt_dat = {24'h00_0000, wake_mask_ff};
                OFS_PIN_STATE:  nxt_dat = {24'h00_0000, line_n};
                default:        nxt_dat = UNMAPPED_DATA;
            endcase
            if (wb_adr_i == OFS_REQ_STATUS)
            begin
                nxt_read_seen = read_seen_ff | flags;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sys_ctrl_ff   <= RST_SYS_CTRL;
            sense_sel_ff  <= RST_SENSE_SEL;
            req_enable_ff <= RST_REQ_ENABLE;
            ctrl_level_ff <= RST_CTRL_LEVEL;
            key_upper_ff  <= RST_KEY_UPPER;
            key_lower_ff  <= RST_KEY_LOWER;
            wake_mask_ff  <= RST_WAKE_MASK;
            read_seen_ff  <= 8'h00;
            dat_ff        <= UNMAPPED_DATA;
            ack_ff        <= 1'b0;
        end
        else
        begin
            sys_ctrl_ff   <= nxt_sys_ctrl;
            sense_sel_ff  <= nxt_sense_sel;
            req_enable_ff <= nxt_req_enable;
            ctrl_level_ff <= nxt_ctrl_level;
            key_upper_ff  <= nxt_key_upper;
            key_lower_ff  <= nxt_key_lower;
            wake_mask_ff  <= nxt_wake_mask;
            read_seen_ff  <= nxt_read_seen;
            dat_ff        <= nxt_dat;
            ack_ff        <= nxt_ack;
        end
    end

    // ========================================================================
    // Request outputs, non-maskable edge and standby wake-up
    always_comb
    begin
        if (sys_ctrl_ff[NMI_EDGE_BIT])
            nmi_edge = nmi_pin && !nmi_prev_ff;
        else
            nmi_edge = !nmi_pin && nmi_prev_ff;
        nxt_nmi_flag  = nmi_edge || (nmi_flag_ff && !nmi_exc_ack);
        nxt_nmi_prev  = nmi_pin;
        nxt_irq_req   = flags & req_enable_ff;
        nxt_irq_level = ctrl_level_ff;
        nxt_periph_req = periph_flag & periph_en & ~periph_dtc_sel;
        nxt_dtc_req    = periph_flag & periph_en & periph_dtc_sel;
        nxt_wake = standby && (nmi_flag_ff || |(irq_req_ff & WAKE_CAPABLE));
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            nmi_prev_ff   <= 1'b0;
            nmi_flag_ff   <= 1'b0;
            irq_req_ff    <= 8'h00;
            irq_level_ff  <= 8'h00;
            periph_req_ff <= '0;
            dtc_req_ff    <= '0;
            wake_ff       <= 1'b0;
        end
        else
        begin
            nmi_prev_ff   <= nxt_nmi_prev;
            nmi_flag_ff   <= nxt_nmi_flag;
            irq_req_ff    <= nxt_irq_req;
            irq_level_ff  <= nxt_irq_level;
            periph_req_ff <= nxt_periph_req;
            dtc_req_ff    <= nxt_dtc_req;
            wake_ff       <= nxt_wake;
        end
    end

    assign wb_dat_o   = dat_ff;
    assign wb_ack_o   = ack_ff;
    assign nmi_req    = nmi_flag_ff;
    assign irq_req    = irq_req_ff;
    assign irq_level  = irq_level_ff;
    assign periph_req = periph_req_ff;
    assign dtc_req    = dtc_req_ff;
    assign wake       = wake_ff;

    // ========================================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    property p_upper_blocks;
        (&key_upper_ff && &wake_mask_ff && irq_pin_n[KEY_IRQ_UPPER]) |-> line7_n;
    endproperty
    a_upper_blocks: assert property (p_upper_blocks) else $error("masked source 7 went low");

    property p_lower_blocks;
        (key_lower_ff == 8'hFF) |-> line6_n;
    endproperty
    a_lower_blocks: assert property (p_lower_blocks) else $error("masked source 6 went low");

    property p_wake_unmasked;
        (|(~wake_event_inputs_n & ~wake_mask_ff)) |-> !line7_n;
    endproperty
    a_wake_unmasked: assert property (p_wake_unmasked) else $error("unmasked wake lost");

    property p_pin7_ignored;
        (!(&key_upper_ff) && !irq_pin_n[KEY_IRQ_UPPER] && &key_sense_inputs_n[15:8]
            && &wake_event_inputs_n) |-> line7_n;
    endproperty
    a_pin7_ignored: assert property (p_pin7_ignored) else $error("pin 7 not ignored");

    property p_enable_gate;
        (req_enable_ff == 8'h00) |=> (irq_req_ff == 8'h00);
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("disabled request forwarded");

    property p_nmi_rise;
        (sys_ctrl_ff[NMI_EDGE_BIT] && nmi_pin && !$past(nmi_pin)) |=> nmi_req;
    endproperty
    a_nmi_rise: assert property (p_nmi_rise) else $error("rising edge not requested");

    property p_no_wake_awake;
        !standby |=> !wake_ff;
    endproperty
    a_no_wake_awake: assert property (p_no_wake_awake) else $error("wake outside standby");

    property p_periph_gate;
        ((periph_flag & periph_en) == '0) |=> (periph_req_ff == '0 && dtc_req_ff == '0);
    endproperty
    a_periph_gate: assert property (p_periph_gate) else $error("peripheral request ungated");

    property p_ack_one;
        ack_ff |=> !ack_ff;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");

    c_key_wake: cover property (!line7_n && !irq_pin_n[KEY_IRQ_UPPER] && pin7_ignored);
    c_sw_clear: cover property (|sw_clear);
    c_wake:     cover property (wake_ff);
    c_nmi:      cover property (nmi_req && irq_req[KEY_IRQ_LOWER]);

endmodule
`default_nettype wire

// ### inc/ekw_pkg.sv
// Constants shared by the external key and wake-up request front end.
package ekw_pkg;

    // ========================================================================
    // Sizes
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int N_IRQ    = 8;
    localparam int N_KEY    = 16;
    localparam int N_WAKE   = 8;
    localparam int N_PERIPH = 4;

    // ========================================================================
    // Register byte offsets
    localparam logic [7:0] OFS_SYS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_SENSE_SEL  = 8'h04;
    localparam logic [7:0] OFS_REQ_ENABLE = 8'h08;
    localparam logic [7:0] OFS_REQ_STATUS = 8'h0C;
    localparam logic [7:0] OFS_CTRL_LEVEL = 8'h10;
    localparam logic [7:0] OFS_KEY_UPPER  = 8'h14;
    localparam logic [7:0] OFS_KEY_LOWER  = 8'h18;
    localparam logic [7:0] OFS_WAKE_MASK  = 8'h1C;
    localparam logic [7:0] OFS_PIN_STATE  = 8'h20;

    // ========================================================================
    // Field positions and reset values
    localparam int          NMI_EDGE_BIT    = 0;
    localparam int          PIN6_MASK_BIT   = 6;
    localparam int          KEY_IRQ_LOWER   = 6;
    localparam int          KEY_IRQ_UPPER   = 7;
    localparam logic [7:0]  RST_SYS_CTRL    = 8'h00;
    localparam logic [15:0] RST_SENSE_SEL   = 16'h0000;
    localparam logic [7:0]  RST_REQ_ENABLE  = 8'h00;
    localparam logic [7:0]  RST_CTRL_LEVEL  = 8'h00;
    localparam logic [7:0]  RST_KEY_UPPER   = 8'hFF;
    localparam logic [7:0]  RST_KEY_LOWER   = 8'hBF;
    localparam logic [7:0]  RST_WAKE_MASK   = 8'hFF;
    localparam logic [7:0]  WAKE_CAPABLE    = 8'hC7;
    localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

    // ========================================================================
    // Sense condition codes
    localparam logic [1:0] SENSE_LOW  = 2'h0;
    localparam logic [1:0] SENSE_FALL = 2'h1;
    localparam logic [1:0] SENSE_RISE = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;

    typedef logic [1:0] ekw_sense_t;

endpackage

// ### logic/ekw_sense.sv
// Sense detector and status flag for one external request source.
`timescale 1ns/100ps
`default_nettype none
module ekw_sense
    import ekw_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               arst_n,
    input  wire logic               line_n,
    input  wire ekw_pkg::ekw_sense_t mode,
    input  wire logic               sw_clear,
    input  wire logic               exc_ack,
    output logic                    flag
);

    logic prev_ff;
    logic flag_ff;
    logic nxt_prev;
    logic nxt_flag;
    logic set_evt;
    logic clr_evt;

    // ========================================================================
    // Detection
    always_comb
    begin
        case (mode)
            SENSE_LOW:  set_evt = !line_n;
            SENSE_FALL: set_evt = prev_ff && !line_n;
            SENSE_RISE: set_evt = !prev_ff && line_n;
            SENSE_BOTH: set_evt = prev_ff != line_n;
            default:    set_evt = 1'b0;
        endcase
        clr_evt = sw_clear || (exc_ack && ((mode != SENSE_LOW) || line_n));
        nxt_flag = set_evt || (flag_ff && !clr_evt);
        nxt_prev = line_n;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prev_ff <= 1'b1;
            flag_ff <= 1'b0;
        end
        else
        begin
            prev_ff <= nxt_prev;
            flag_ff <= nxt_flag;
        end
    end

    assign flag = flag_ff;

    // ========================================================================
    // Checks
    property p_fall_sets;
        @(posedge clock) disable iff (!arst_n)
        (mode == SENSE_FALL && prev_ff && !line_n) |=> flag_ff;
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("falling edge did not set flag");

    property p_edge_autoclear;
        @(posedge clock) disable iff (!arst_n)
        (exc_ack && mode != SENSE_LOW && !set_evt) |=> !flag_ff;
    endproperty
    a_edge_autoclear: assert property (p_edge_autoclear) else $error("flag kept after exception");

    property p_low_hold;
        @(posedge clock) disable iff (!arst_n)
        (mode == SENSE_LOW && !line_n) |=> flag_ff;
    endproperty
    a_low_hold: assert property (p_low_hold) else $error("low level not flagged");

endmodule
`default_nettype wire

// ### tb/ekw_far_side.sv
// Far-side model of the key matrix, wake sources and request pins.
`timescale 1ns/100ps
`default_nettype none
module ekw_far_side
(
    input  wire logic                        clock,
    output logic                             nmi_pin,
    output logic [ekw_pkg::N_IRQ-1:0]        irq_pin_n,
    output logic [ekw_pkg::N_KEY-1:0]        key_sense_inputs_n,
    output logic [ekw_pkg::N_WAKE-1:0]       wake_event_inputs_n
);
    import ekw_pkg::*;

    // ========================================================================
    // Line levels
    // The active-low lines have pull-ups, so an idle line reads high.
    initial
    begin
        nmi_pin = 1'b0;
        irq_pin_n = '1;
        key_sense_inputs_n = '1;
        wake_event_inputs_n = '1;
    end

    // Group 0 request pins, 1 keys, 2 wake inputs, other the non-maskable pin.
    task automatic drive(input int grp, input int idx, input logic lvl);
        @(posedge clock);
        case (grp)
            0: irq_pin_n[idx] <= lvl;
            1: key_sense_inputs_n[idx] <= lvl;
            2: wake_event_inputs_n[idx] <= lvl;
            default: nmi_pin <= lvl;
        endcase
    endtask
endmodule
`default_nettype wire

// ### tb/test_ekw_top.sv
// Self-checking bench for the key and wake-up request front end.
`timescale 1ns/100ps
`default_nettype none
module test_ekw_top;
    import ekw_pkg::*;

    // ========================================================================
    // Signals
    logic        clock;
    logic        arst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack;
    logic        nmi_pin;
    logic [7:0]  irq_pin_n;
    logic [15:0] keys_n;
    logic [7:0]  wakes_n;
    logic        nmi_ack;
    logic [7:0]  irq_ack;
    logic        standby;
    logic [3:0]  pflag;
    logic [3:0]  pen;
    logic [3:0]  psel;
    logic        nmi_req;
    logic [7:0]  irq_req;
    logic [7:0]  irq_level;
    logic [3:0]  preq;
    logic [3:0]  dreq;
    logic        wake;
    int          num_errors;
    int          n_tests;

    ekw_top dut (.clock(clock), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .nmi_pin(nmi_pin), .irq_pin_n(irq_pin_n),
        .key_sense_inputs_n(keys_n), .wake_event_inputs_n(wakes_n),
        .nmi_exc_ack(nmi_ack), .irq_exc_ack(irq_ack), .standby(standby),
        .periph_flag(pflag), .periph_en(pen), .periph_dtc_sel(psel),
        .nmi_req(nmi_req), .irq_req(irq_req), .irq_level(irq_level),
        .periph_req(preq), .dtc_req(dreq), .wake(wake));

    ekw_far_side far (.clock(clock), .nmi_pin(nmi_pin), .irq_pin_n(irq_pin_n),
        .key_sense_inputs_n(keys_n), .wake_event_inputs_n(wakes_n));

    // ========================================================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // The slave's latency is not assumed; only the watchdog ends a hang.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge clock);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        do
            @(posedge clock);
        while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(what, exp, q);
    endtask

    task automatic pulse_ack(input int idx);
        @(posedge clock);
        irq_ack[idx] <= 1'b1;
        @(posedge clock);
        irq_ack[idx] <= 1'b0;
        tick(2);
    endtask

    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ========================================================================
    // Scenarios
    task automatic t_reset();
        rd("key_upper", OFS_KEY_UPPER, 32'h0000_00FF);
        rd("key_lower", OFS_KEY_LOWER, 32'h0000_00BF);
        rd("wake_mask", OFS_WAKE_MASK, 32'h0000_00FF);
        rd("unmapped", 8'h3C, 32'h0000_0000);
        bus(1'b1, OFS_KEY_UPPER, 32'h0, 4'h0);
        rd("lane_off", OFS_KEY_UPPER, 32'h0000_00FF);
    endtask

    task automatic t_lower_keys();
        wr(OFS_SENSE_SEL, 32'h0000_5000);
        wr(OFS_REQ_ENABLE, 32'h0000_00C0);
        wr(OFS_KEY_LOWER, 32'h0000_00BE);
        far.drive(1, 1, 1'b0);
        tick(3);
        rd("masked_key", OFS_REQ_STATUS, 32'h0);
        far.drive(1, 0, 1'b0);
        tick(3);
        chk("irq_req6", 32'h40, {24'h0, irq_req});
        far.drive(1, 0, 1'b1);
        far.drive(1, 1, 1'b1);
        rd("key_flag", OFS_REQ_STATUS, 32'h0000_0040);
        wr(OFS_REQ_STATUS, 32'h0000_00BF);
        far.drive(0, 6, 1'b0);
        tick(3);
        far.drive(0, 6, 1'b1);
        rd("pin6", OFS_REQ_STATUS, 32'h0000_0040);
        wr(OFS_REQ_STATUS, 32'h0000_00BF);
        rd("key_clr", OFS_REQ_STATUS, 32'h0);
    endtask

    task automatic t_upper();
        standby <= 1'b1;
        wr(OFS_KEY_UPPER, 32'h0000_00FE);
        far.drive(1, 8, 1'b0);
        tick(4);
        chk("wake", 32'h1, {31'h0, wake});
        far.drive(1, 8, 1'b1);
        rd("key8", OFS_REQ_STATUS, 32'h0000_0080);
        wr(OFS_REQ_STATUS, 32'h0000_007F);
        far.drive(0, 7, 1'b0);
        tick(3);
        far.drive(0, 7, 1'b1);
        rd("pin7_off", OFS_REQ_STATUS, 32'h0);
        wr(OFS_KEY_UPPER, 32'h0000_00FF);
        wr(OFS_WAKE_MASK, 32'h0000_00FE);
        far.drive(2, 0, 1'b0);
        tick(3);
        far.drive(2, 0, 1'b1);
        rd("wake0", OFS_REQ_STATUS, 32'h0000_0080);
        wr(OFS_REQ_STATUS, 32'h0000_007F);
        wr(OFS_WAKE_MASK, 32'h0000_00FF);
        far.drive(0, 7, 1'b0);
        tick(3);
        far.drive(0, 7, 1'b1);
        rd("pin7_on", OFS_REQ_STATUS, 32'h0000_0080);
        wr(OFS_REQ_STATUS, 32'h0000_007F);
        standby <= 1'b0;
    endtask

    task automatic t_sense();
        logic [3:0] pe;
        logic [3:0] re;
        pe = 4'b1011;
        re = 4'b1101;
        wr(OFS_REQ_ENABLE, 32'h0);
        for (int m = 0; m < 4; m++)
        begin
            wr(OFS_SENSE_SEL, 32'(m));
            far.drive(0, 0, 1'b0);
            tick(3);
            chk("no_enable", 32'h0, {24'h0, irq_req});
            rd("st_press", OFS_REQ_STATUS, {31'h0, pe[m]});
            wr(OFS_REQ_STATUS, 32'h0000_00FE);
            far.drive(0, 0, 1'b1);
            tick(3);
            rd("st_rel", OFS_REQ_STATUS, {31'h0, re[m]});
            wr(OFS_REQ_STATUS, 32'h0000_00FE);
        end
        wr(OFS_SENSE_SEL, 32'h0);
        wr(OFS_REQ_ENABLE, 32'h0000_0001);
        far.drive(0, 0, 1'b0);
        tick(3);
        chk("irq_req0", 32'h1, {24'h0, irq_req});
        pulse_ack(0);
        rd("ack_low", OFS_REQ_STATUS, 32'h0000_0001);
        far.drive(0, 0, 1'b1);
        pulse_ack(0);
        rd("ack_high", OFS_REQ_STATUS, 32'h0);
    endtask

    task automatic t_nmi();
        wr(OFS_SYS_CTRL, 32'h0000_0001);
        far.drive(3, 0, 1'b1);
        tick(3);
        chk("nmi_rise", 32'h1, {31'h0, nmi_req});
        nmi_ack <= 1'b1;
        @(posedge clock);
        nmi_ack <= 1'b0;
        wr(OFS_SYS_CTRL, 32'h0);
        chk("nmi_clr", 32'h0, {31'h0, nmi_req});
        far.drive(3, 0, 1'b0);
        tick(3);
        chk("nmi_fall", 32'h1, {31'h0, nmi_req});
    endtask

    task automatic t_periph();
        wr(OFS_CTRL_LEVEL, 32'h0000_00A5);
        tick(1);
        chk("level", 32'hA5, {24'h0, irq_level});
        {pflag, pen, psel} <= 12'h732;
        tick(3);
        chk("periph", 32'h1, {28'h0, preq});
        chk("dtc", 32'h2, {28'h0, dreq});
    endtask

    // ========================================================================
    // Clock, watchdog and main sequence
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial
    begin
        #200000;
        num_errors++;
        report_and_stop();
    end

    initial
    begin
        {arst_n, cyc, stb, we, nmi_ack, standby} = '0;
        {adr, wdat, sel, irq_ack, pflag, pen, psel} = '0;
        num_errors = 0;
        n_tests = 0;
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        t_reset();
        t_lower_keys();
        t_upper();
        t_sense();
        t_nmi();
        t_periph();
        report_and_stop();
    end
endmodule
`default_nettype wire
